// ---- thm_pkg.sv ----
// Purpose: shared constants for the temperature monitor register map
// Assumes: 8-bit registers, 8-bit register pointer, 100 MHz clock
// Notes:   storage indices are internal; addresses are the bus view
package thm_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLOCK_KHZ        = 100000;
  localparam int unsigned BUS_TIMEOUT_MS   = 25;
  localparam int unsigned BUS_TIMEOUT_CYC  = BUS_TIMEOUT_MS * CLOCK_KHZ;
  localparam int unsigned TIMEOUT_CNT_W    = 22;

  // ****************************************
  // read addresses
  // ****************************************
  localparam logic [7:0] RD_LOCAL_VAL      = 8'h00;
  localparam logic [7:0] RD_REMOTE_VAL_HI  = 8'h01;
  localparam logic [7:0] RD_STATUS_FIRST   = 8'h02;
  localparam logic [7:0] RD_CONFIG_FIRST   = 8'h03;
  localparam logic [7:0] RD_CONV_RATE      = 8'h04;
  localparam logic [7:0] RD_LOCAL_HI_LIM   = 8'h05;
  localparam logic [7:0] RD_LOCAL_LO_LIM   = 8'h06;
  localparam logic [7:0] RD_REMOTE_HI_HI   = 8'h07;
  localparam logic [7:0] RD_REMOTE_LO_HI   = 8'h08;
  localparam logic [7:0] RD_REMOTE_VAL_LO  = 8'h10;
  localparam logic [7:0] RD_STATUS_SECOND  = 8'h23;
  localparam logic [7:0] RD_B_VAL_HI       = 8'h30;
  localparam logic [7:0] RD_B_VAL_LO       = 8'h33;
  localparam logic [7:0] RD_MAKER_ID       = 8'hfe;
  localparam logic [7:0] RD_SILICON_REV    = 8'hff;

  // ****************************************
  // write-only aliases
  // ****************************************
  localparam logic [7:0] WR_CONFIG_FIRST   = 8'h09;
  localparam logic [7:0] WR_CONV_RATE      = 8'h0a;
  localparam logic [7:0] WR_LOCAL_HI_LIM   = 8'h0b;
  localparam logic [7:0] WR_LOCAL_LO_LIM   = 8'h0c;
  localparam logic [7:0] WR_REMOTE_HI_HI   = 8'h0d;
  localparam logic [7:0] WR_REMOTE_LO_HI   = 8'h0e;
  localparam logic [7:0] WR_SINGLE_CONV    = 8'h0f;

  // ****************************************
  // shared read/write addresses
  // ****************************************
  localparam logic [7:0] RW_REMOTE_OFS_HI  = 8'h11;
  localparam logic [7:0] RW_REMOTE_OFS_LO  = 8'h12;
  localparam logic [7:0] RW_REMOTE_HI_LO   = 8'h13;
  localparam logic [7:0] RW_REMOTE_LO_LO   = 8'h14;
  localparam logic [7:0] RW_REMOTE_OT_LIM  = 8'h19;
  localparam logic [7:0] RW_LOCAL_OT_LIM   = 8'h20;
  localparam logic [7:0] RW_OT_HYST        = 8'h21;
  localparam logic [7:0] RW_ALERT_FILTER   = 8'h22;
  localparam logic [7:0] RW_CONFIG_SECOND  = 8'h24;
  localparam logic [7:0] RW_B_HI_HI        = 8'h31;
  localparam logic [7:0] RW_B_LO_HI        = 8'h32;
  localparam logic [7:0] RW_B_OFS_HI       = 8'h34;
  localparam logic [7:0] RW_B_OFS_LO       = 8'h35;
  localparam logic [7:0] RW_B_HI_LO        = 8'h36;
  localparam logic [7:0] RW_B_LO_LO        = 8'h37;
  localparam logic [7:0] RW_B_OT_LIM       = 8'h39;

  // ****************************************
  // storage indices of writable registers
  // ****************************************
  localparam int unsigned IX_CFG1   = 0;
  localparam int unsigned IX_RATE   = 1;
  localparam int unsigned IX_LHI    = 2;
  localparam int unsigned IX_LLO    = 3;
  localparam int unsigned IX_AHH    = 4;
  localparam int unsigned IX_ALH    = 5;
  localparam int unsigned IX_AOFH   = 6;
  localparam int unsigned IX_AOFL   = 7;
  localparam int unsigned IX_AHL    = 8;
  localparam int unsigned IX_ALL    = 9;
  localparam int unsigned IX_AOT    = 10;
  localparam int unsigned IX_LOT    = 11;
  localparam int unsigned IX_HYST   = 12;
  localparam int unsigned IX_FILT   = 13;
  localparam int unsigned IX_CFG2   = 14;
  localparam int unsigned IX_BHH    = 15;
  localparam int unsigned IX_BLH    = 16;
  localparam int unsigned IX_BOFH   = 17;
  localparam int unsigned IX_BOFL   = 18;
  localparam int unsigned IX_BHL    = 19;
  localparam int unsigned IX_BLL    = 20;
  localparam int unsigned IX_BOT    = 21;
  localparam int unsigned NREG      = 22;
  localparam int unsigned IX_NONE   = 31;

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_CONV_RATE     = 8'h07;
  localparam logic [7:0] RST_LIMIT_85C     = 8'h55;
  localparam logic [7:0] RST_HYST_10C      = 8'h0a;
  localparam logic [7:0] RST_ALERT_FILTER  = 8'h01;
  localparam int unsigned CFG1_BANK_BIT    = 3;
  localparam int unsigned FILT_SCL_TO_BIT  = 7;
  localparam int unsigned FILT_SDA_TO_BIT  = 6;
  localparam int unsigned FILT_MASK_BIT    = 4;
  localparam int unsigned FILT_CNT_LSB     = 1;
  localparam int unsigned FILT_CNT_W       = 3;
  localparam int unsigned NCHAN            = 3;
  localparam logic [1:0] CH_LOCAL          = 2'h0;
  localparam logic [1:0] CH_REMOTE_A       = 2'h1;
  localparam logic [1:0] CH_REMOTE_B       = 2'h2;

  function automatic logic [7:0] reset_value(input int unsigned idx);
    case (idx)
      IX_RATE:                                       reset_value = RST_CONV_RATE;
      IX_LHI, IX_AHH, IX_AOT, IX_LOT, IX_BHH, IX_BOT: reset_value = RST_LIMIT_85C;
      IX_HYST:                                       reset_value = RST_HYST_10C;
      IX_FILT:                                       reset_value = RST_ALERT_FILTER;
      default:                                       reset_value = RST_ZERO;
    endcase
  endfunction : reset_value

endpackage : thm_pkg

// ---- thm_alert_filter.sv ----
// Purpose: consecutive out-of-limit filter for one channel
// Assumes: one result strobe per finished measurement
// Notes:   need code is a thermometer; ones plus one gives the count
`timescale 1ns/1ps
module thm_alert_filter (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // measurement result
  input  wire logic       result_valid,
  input  wire logic       out_of_limit,
  input  wire logic [2:0] need_code,
  // filtered alert level
  output logic            fire
);

  typedef struct packed {
    logic [2:0] run;
    logic       fire;
  } thm_filt_state_t;

  thm_filt_state_t st_ff;
  thm_filt_state_t nxt_st;
  logic [2:0]      need;

  always_comb begin
    nxt_st = st_ff;
    // R1 - count needed from code
    need = 3'h1 + 3'(need_code[0]) + 3'(need_code[1]) + 3'(need_code[2]);
    if (result_valid) begin
      if (out_of_limit) begin
        // saturate so a long excursion cannot wrap the run
        if (st_ff.run < need) begin
          nxt_st.run = st_ff.run + 3'h1;
        end
        // R1 - alert after the run
        if (st_ff.run + 3'h1 >= need) begin
          nxt_st.fire = 1'b1;
        end
      end else begin
        // R12 - restart on in-limit
        nxt_st.run  = 3'h0;
        nxt_st.fire = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fire = st_ff.fire;

endmodule : thm_alert_filter

// ---- thm_regmap.sv ----
// Purpose: register map, alert filters and bus timeouts of the monitor
// Assumes: serial front end gives one-cycle register read/write strobes
// Notes:   read and write addresses differ for several registers
//
// How it works
// R1 - alert only after the programmed run of out-of-limit results, up to four
// R2 - alert filter register resets to 01, one result suffices
// R3 - filter bit 7 enables clock timeout, bit 6 data timeout, both off
// R4 - filter bit 4 masks the local alert; bit 0 does nothing
// R5 - config bit 3 selects second remote channel at shared addresses
// R6 - write to 0F starts one measurement; data is dropped
// R7 - high and over-temperature limits reset to 55
// R8 - over-temperature hysteresis resets to 0A
// R9 - no averaging at the three fastest conversion rates
// R10 - enabled timeout abandons a transfer after 25 ms of stuck line
// R11 - single measurement in standby covers all channels, then standby
// R12 - an in-limit result restarts that channel's run count
// R13 - writes to addresses without write function change nothing
`timescale 1ns/1ps
module thm_regmap #(
  parameter int unsigned TIMEOUT_CYCLES  = thm_pkg::BUS_TIMEOUT_CYC,
  parameter logic [7:0]  MAKER_ID        = 8'h5a, // arbitrary value
  parameter logic [7:0]  SILICON_REV     = 8'h01, // arbitrary value
  parameter logic [7:0]  FAST_RATE_FIRST = 8'h08
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // register access from the serial front end
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // status bytes from the flag logic
  input  wire logic [7:0]  status_first_in,
  input  wire logic [7:0]  status_second_in,
  // measurement results
  input  wire logic        meas_valid,
  input  wire logic [1:0]  meas_chan,
  input  wire logic [7:0]  meas_high,
  input  wire logic [7:0]  meas_low,
  input  wire logic        meas_out_of_limit,
  // bus line levels
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  // control towards the converter and front end
  output logic             conversion_start,
  output logic             averaging_enable,
  output logic [7:0]       config_first,
  output logic [7:0]       conversion_rate,
  output logic [7:0]       overtemp_hysteresis,
  output logic [2:0]       alert_chan,
  output logic             alert_request,
  output logic             bus_abort
);

  localparam int unsigned W = thm_pkg::TIMEOUT_CNT_W;

  typedef struct packed {
    logic [thm_pkg::NREG-1:0][7:0] regs;
    logic [7:0]                    local_val;
    logic [7:0]                    a_val_hi;
    logic [7:0]                    a_val_lo;
    logic [7:0]                    b_val_hi;
    logic [7:0]                    b_val_lo;
    logic [7:0]                    rdata;
    logic                          rvalid;
    logic                          start;
    logic                          avg;
    logic [2:0]                    alert_chan;
    logic                          alert;
    logic [1:0]                    scl_sync;
    logic [1:0]                    sda_sync;
    logic [W-1:0]                  scl_cnt;
    logic [W-1:0]                  sda_cnt;
    logic                          abort;
  } thm_state_t;

  thm_state_t  st_ff;
  thm_state_t  nxt_st;
  logic [2:0]  fire;
  logic        bank_b;
  logic [4:0]  wr_ix;
  logic [7:0]  filt;

  assign bank_b = st_ff.regs[thm_pkg::IX_CFG1][thm_pkg::CFG1_BANK_BIT];
  assign filt   = st_ff.regs[thm_pkg::IX_FILT];

  // ****************************************
  // per-channel consecutive filters
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < thm_pkg::NCHAN; gi++) begin : g_filt
      thm_alert_filter u_filt (
        .clock        (clock),
        .nrst         (nrst),
        .result_valid (meas_valid && (meas_chan == 2'(gi))),
        .out_of_limit (meas_out_of_limit),
        .need_code    (filt[thm_pkg::FILT_CNT_LSB +: thm_pkg::FILT_CNT_W]),
        .fire         (fire[gi])
      );
    end
  endgenerate

  // ****************************************
  // write address to storage index
  // ****************************************
  always_comb begin
    // R13 - unmapped writes go nowhere
    wr_ix = 5'(thm_pkg::IX_NONE);
    case (reg_addr)
      thm_pkg::WR_CONFIG_FIRST:  wr_ix = 5'(thm_pkg::IX_CFG1);
      thm_pkg::WR_CONV_RATE:     wr_ix = 5'(thm_pkg::IX_RATE);
      thm_pkg::WR_LOCAL_HI_LIM:  wr_ix = 5'(thm_pkg::IX_LHI);
      thm_pkg::WR_LOCAL_LO_LIM:  wr_ix = 5'(thm_pkg::IX_LLO);
      // R5 - bank select on writes
      thm_pkg::WR_REMOTE_HI_HI:  wr_ix = bank_b ? 5'(thm_pkg::IX_BHH)  : 5'(thm_pkg::IX_AHH);
      thm_pkg::WR_REMOTE_LO_HI:  wr_ix = bank_b ? 5'(thm_pkg::IX_BLH)  : 5'(thm_pkg::IX_ALH);
      thm_pkg::RW_REMOTE_OFS_HI: wr_ix = bank_b ? 5'(thm_pkg::IX_BOFH) : 5'(thm_pkg::IX_AOFH);
      thm_pkg::RW_REMOTE_OFS_LO: wr_ix = bank_b ? 5'(thm_pkg::IX_BOFL) : 5'(thm_pkg::IX_AOFL);
      thm_pkg::RW_REMOTE_HI_LO:  wr_ix = bank_b ? 5'(thm_pkg::IX_BHL)  : 5'(thm_pkg::IX_AHL);
      thm_pkg::RW_REMOTE_LO_LO:  wr_ix = bank_b ? 5'(thm_pkg::IX_BLL)  : 5'(thm_pkg::IX_ALL);
      thm_pkg::RW_REMOTE_OT_LIM: wr_ix = bank_b ? 5'(thm_pkg::IX_BOT)  : 5'(thm_pkg::IX_AOT);
      thm_pkg::RW_LOCAL_OT_LIM:  wr_ix = 5'(thm_pkg::IX_LOT);
      thm_pkg::RW_OT_HYST:       wr_ix = 5'(thm_pkg::IX_HYST);
      thm_pkg::RW_ALERT_FILTER:  wr_ix = 5'(thm_pkg::IX_FILT);
      thm_pkg::RW_CONFIG_SECOND: wr_ix = 5'(thm_pkg::IX_CFG2);
      thm_pkg::RW_B_HI_HI:       wr_ix = 5'(thm_pkg::IX_BHH);
      thm_pkg::RW_B_LO_HI:       wr_ix = 5'(thm_pkg::IX_BLH);
      thm_pkg::RW_B_OFS_HI:      wr_ix = 5'(thm_pkg::IX_BOFH);
      thm_pkg::RW_B_OFS_LO:      wr_ix = 5'(thm_pkg::IX_BOFL);
      thm_pkg::RW_B_HI_LO:       wr_ix = 5'(thm_pkg::IX_BHL);
      thm_pkg::RW_B_LO_LO:       wr_ix = 5'(thm_pkg::IX_BLL);
      thm_pkg::RW_B_OT_LIM:      wr_ix = 5'(thm_pkg::IX_BOT);
      default:                   wr_ix = 5'(thm_pkg::IX_NONE);
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.start  = 1'b0;
    nxt_st.abort  = 1'b0;

    // register writes
    if (reg_wr) begin
      if (wr_ix < 5'(thm_pkg::NREG)) begin
        nxt_st.regs[wr_ix] = reg_wdata;
      end
      // R6 - trigger only, data dropped
      if (reg_addr == thm_pkg::WR_SINGLE_CONV) begin
        nxt_st.start = 1'b1;
      end
    end

    // register reads, answered one cycle later
    if (reg_rd) begin
      nxt_st.rvalid = 1'b1;
      case (reg_addr)
        thm_pkg::RD_LOCAL_VAL:     nxt_st.rdata = st_ff.local_val;
        // R5 - bank select on reads
        thm_pkg::RD_REMOTE_VAL_HI: nxt_st.rdata = bank_b ? st_ff.b_val_hi : st_ff.a_val_hi;
        thm_pkg::RD_REMOTE_VAL_LO: nxt_st.rdata = bank_b ? st_ff.b_val_lo : st_ff.a_val_lo;
        thm_pkg::RD_STATUS_FIRST:  nxt_st.rdata = status_first_in;
        thm_pkg::RD_CONFIG_FIRST:  nxt_st.rdata = st_ff.regs[thm_pkg::IX_CFG1];
        thm_pkg::RD_CONV_RATE:     nxt_st.rdata = st_ff.regs[thm_pkg::IX_RATE];
        thm_pkg::RD_LOCAL_HI_LIM:  nxt_st.rdata = st_ff.regs[thm_pkg::IX_LHI];
        thm_pkg::RD_LOCAL_LO_LIM:  nxt_st.rdata = st_ff.regs[thm_pkg::IX_LLO];
        thm_pkg::RD_REMOTE_HI_HI:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BHH : thm_pkg::IX_AHH];
        thm_pkg::RD_REMOTE_LO_HI:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BLH : thm_pkg::IX_ALH];
        thm_pkg::RW_REMOTE_OFS_HI:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BOFH : thm_pkg::IX_AOFH];
        thm_pkg::RW_REMOTE_OFS_LO:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BOFL : thm_pkg::IX_AOFL];
        thm_pkg::RW_REMOTE_HI_LO:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BHL : thm_pkg::IX_AHL];
        thm_pkg::RW_REMOTE_LO_LO:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BLL : thm_pkg::IX_ALL];
        thm_pkg::RW_REMOTE_OT_LIM:
          nxt_st.rdata = st_ff.regs[bank_b ? thm_pkg::IX_BOT : thm_pkg::IX_AOT];
        thm_pkg::RW_LOCAL_OT_LIM:  nxt_st.rdata = st_ff.regs[thm_pkg::IX_LOT];
        thm_pkg::RW_OT_HYST:       nxt_st.rdata = st_ff.regs[thm_pkg::IX_HYST];
        thm_pkg::RW_ALERT_FILTER:  nxt_st.rdata = st_ff.regs[thm_pkg::IX_FILT];
        thm_pkg::RD_STATUS_SECOND: nxt_st.rdata = status_second_in;
        thm_pkg::RW_CONFIG_SECOND: nxt_st.rdata = st_ff.regs[thm_pkg::IX_CFG2];
        thm_pkg::RD_B_VAL_HI:      nxt_st.rdata = st_ff.b_val_hi;
        thm_pkg::RW_B_HI_HI:       nxt_st.rdata = st_ff.regs[thm_pkg::IX_BHH];
        thm_pkg::RW_B_LO_HI:       nxt_st.rdata = st_ff.regs[thm_pkg::IX_BLH];
        thm_pkg::RD_B_VAL_LO:      nxt_st.rdata = st_ff.b_val_lo;
        thm_pkg::RW_B_OFS_HI:      nxt_st.rdata = st_ff.regs[thm_pkg::IX_BOFH];
        thm_pkg::RW_B_OFS_LO:      nxt_st.rdata = st_ff.regs[thm_pkg::IX_BOFL];
        thm_pkg::RW_B_HI_LO:       nxt_st.rdata = st_ff.regs[thm_pkg::IX_BHL];
        thm_pkg::RW_B_LO_LO:       nxt_st.rdata = st_ff.regs[thm_pkg::IX_BLL];
        thm_pkg::RW_B_OT_LIM:      nxt_st.rdata = st_ff.regs[thm_pkg::IX_BOT];
        thm_pkg::RD_MAKER_ID:      nxt_st.rdata = MAKER_ID;
        thm_pkg::RD_SILICON_REV:   nxt_st.rdata = SILICON_REV;
        default:                   nxt_st.rdata = 8'h00;
      endcase
    end

    // measurement capture; value registers are read-only to the bus
    if (meas_valid) begin
      case (meas_chan)
        thm_pkg::CH_LOCAL: begin
          nxt_st.local_val = meas_high;
        end
        thm_pkg::CH_REMOTE_A: begin
          nxt_st.a_val_hi = meas_high;
          nxt_st.a_val_lo = meas_low;
        end
        thm_pkg::CH_REMOTE_B: begin
          nxt_st.b_val_hi = meas_high;
          nxt_st.b_val_lo = meas_low;
        end
        default: begin
          nxt_st.local_val = st_ff.local_val;
        end
      endcase
    end

    // R9 - averaging off at fast rates
    nxt_st.avg = st_ff.regs[thm_pkg::IX_RATE] < FAST_RATE_FIRST;

    // R4 - internal alert mask
    nxt_st.alert_chan = {fire[2], fire[1], fire[0] & ~filt[thm_pkg::FILT_MASK_BIT]};
    nxt_st.alert      = |nxt_st.alert_chan;

    // line synchronisers
    nxt_st.scl_sync = {st_ff.scl_sync[0], scl_pin};
    nxt_st.sda_sync = {st_ff.sda_sync[0], sda_pin};

    // R3 - clock line timeout enable
    if (!filt[thm_pkg::FILT_SCL_TO_BIT] || st_ff.scl_sync[1]) begin
      nxt_st.scl_cnt = '0;
    end else if (st_ff.scl_cnt == W'(TIMEOUT_CYCLES - 1)) begin
      // R10 - abandon after stuck line
      nxt_st.abort   = 1'b1;
      nxt_st.scl_cnt = '0;
    end else begin
      nxt_st.scl_cnt = st_ff.scl_cnt + W'(1);
    end

    // R3 - data line timeout enable
    if (!filt[thm_pkg::FILT_SDA_TO_BIT] || st_ff.sda_sync[1]) begin
      nxt_st.sda_cnt = '0;
    end else if (st_ff.sda_cnt == W'(TIMEOUT_CYCLES - 1)) begin
      // R10 - abandon after stuck line
      nxt_st.abort   = 1'b1;
      nxt_st.sda_cnt = '0;
    end else begin
      nxt_st.sda_cnt = st_ff.sda_cnt + W'(1);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_ff <= '0;
      // R2 R7 R8 - power-on defaults
      for (int i = 0; i < thm_pkg::NREG; i++) begin
        st_ff.regs[i] <= thm_pkg::reset_value(i);
      end
      // lines idle high so a held reset does not look like a stuck bus
      st_ff.scl_sync <= 2'h3;
      st_ff.sda_sync <= 2'h3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata           = st_ff.rdata;
  assign reg_rvalid          = st_ff.rvalid;
  // R11 - one pulse starts all channels
  assign conversion_start    = st_ff.start;
  assign averaging_enable    = st_ff.avg;
  assign config_first        = st_ff.regs[thm_pkg::IX_CFG1];
  assign conversion_rate     = st_ff.regs[thm_pkg::IX_RATE];
  assign overtemp_hysteresis = st_ff.regs[thm_pkg::IX_HYST];
  assign alert_chan          = st_ff.alert_chan;
  assign alert_request       = st_ff.alert;
  assign bus_abort           = st_ff.abort;

endmodule : thm_regmap

// ---- thm_regmap_sva.sv ----
// Purpose: port-level checks of the monitor register map
// Assumes: one clock, synchronous active-low reset
// Notes:   alert checks watch remote channel A only
`timescale 1ns/1ps
module thm_regmap_sva #(
  parameter logic [7:0] FAST_RATE_FIRST = 8'h08
) (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       meas_valid,
  input wire logic [1:0] meas_chan,
  input wire logic       meas_out_of_limit,
  input wire logic       conversion_start,
  input wire logic       averaging_enable,
  input wire logic [7:0] config_first,
  input wire logic [7:0] conversion_rate,
  input wire logic [7:0] overtemp_hysteresis,
  input wire logic [2:0] alert_chan,
  input wire logic       bus_abort
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_start_pulse: assert property (reg_wr && reg_addr == 8'h0f |=> conversion_start)
    else $error("no start pulse after trigger write");
  chk_start_cause: assert property (conversion_start |-> $past(reg_wr && reg_addr == 8'h0f))
    else $error("start pulse without trigger write");
  chk_reset_vals: assert property ($rose(nrst) |-> conversion_rate == 8'h07 && overtemp_hysteresis == 8'h0a)
    else $error("wrong value after reset");
  chk_rate_hold: assert property (!(reg_wr && reg_addr == 8'h0a) |=> $stable(conversion_rate))
    else $error("rate changed without its write");
  chk_cfg_write: assert property (reg_wr && reg_addr == 8'h09 |=> config_first == $past(reg_wdata))
    else $error("config write not stored");
  chk_no_average: assert property (conversion_rate >= FAST_RATE_FIRST && $past(conversion_rate) >= FAST_RATE_FIRST |-> !averaging_enable)
    else $error("averaging at a fast rate");
  chk_alert_cause: assert property ($rose(alert_chan[1]) |-> $past(meas_valid && meas_out_of_limit && meas_chan == 2'h1, 2))
    else $error("alert without out-of-limit result");
  chk_alert_clear: assert property (meas_valid && !meas_out_of_limit && meas_chan == 2'h1 |-> ##2 !alert_chan[1])
    else $error("alert kept after in-limit result");
  cov_start: cover property (conversion_start);
  cov_alert: cover property ($rose(alert_chan[1]));
  cov_abort: cover property (bus_abort);
endmodule : thm_regmap_sva
bind thm_regmap thm_regmap_sva #(.FAST_RATE_FIRST(FAST_RATE_FIRST)) u_sva (
  .clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_out_of_limit(meas_out_of_limit),
  .conversion_start(conversion_start), .averaging_enable(averaging_enable),
  .config_first(config_first), .conversion_rate(conversion_rate),
  .overtemp_hysteresis(overtemp_hysteresis), .alert_chan(alert_chan), .bus_abort(bus_abort));

// ---- thm_host.sv ----
// Purpose: host master model issuing register strobes
// Assumes: strobes sampled on the rising edge
// Notes:   released address and data show inverted values
`timescale 1ns/1ps
module thm_host (
  // clock
  input  wire logic       clock,
  // register strobes
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  // read answer
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // bounded wait; no answer leaves unknown data for the caller to reject
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 'x;
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~a;
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask : rd
endmodule : thm_host

// ---- thm_regmap_tb_top.sv ----
// Purpose: self-checking bench of the monitor register map
// Assumes: inputs change on the falling edge
// Notes:   timeout shortened to 20 cycles
`timescale 1ns/1ps
module thm_regmap_tb_top;
  logic clock = 1'b0, nrst = 1'b0, reg_wr, reg_rd, reg_rvalid, conversion_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, config_first, conversion_rate, overtemp_hysteresis;
  logic meas_valid = 1'b0, meas_out_of_limit = 1'b0, scl_pin = 1'b1, sda_pin = 1'b1;
  logic [1:0] meas_chan = 2'h0;
  logic [7:0] meas_high = 8'h00, meas_low = 8'h00;
  logic averaging_enable, alert_request, bus_abort;
  logic [2:0] alert_chan;
  int err_count = 0, total_checks = 0;
  always #5 clock = ~clock;
  thm_host host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  thm_regmap #(.TIMEOUT_CYCLES(20)) DUT (.clock(clock), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .status_first_in(8'h5c), .status_second_in(8'h03),
    .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_high(meas_high),
    .meas_low(meas_low), .meas_out_of_limit(meas_out_of_limit), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .conversion_start(conversion_start), .averaging_enable(averaging_enable),
    .config_first(config_first), .conversion_rate(conversion_rate),
    .overtemp_hysteresis(overtemp_hysteresis), .alert_chan(alert_chan),
    .alert_request(alert_request), .bus_abort(bus_abort));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    check(d, e);
  endtask : rd_chk
  task automatic meas(input logic [1:0] ch, input logic oor);
    @(negedge clock);
    meas_valid = 1'b1;
    meas_chan = ch;
    meas_out_of_limit = oor;
    meas_high = 8'h60;
    @(negedge clock);
    meas_valid = 1'b0;
    repeat (2) @(negedge clock);
  endtask : meas
  // bit 0 is set in the second code: it must not change the count
  task automatic filt(input logic [7:0] code, input int need);
    host.wr(8'h22, code);
    for (int i = 1; i < need; i++) begin
      meas(2'h1, 1'b1);
      check({7'h00, alert_chan[1]}, 8'h00);
    end
    meas(2'h1, 1'b1);
    check({7'h00, alert_chan[1]}, 8'h01);
    meas(2'h1, 1'b0);
    check({7'h00, alert_chan[1]}, 8'h00);
  endtask : filt
  task automatic tmo(input logic [7:0] f, input logic ln, input logic e);
    logic hit;
    hit = 1'b0;
    host.wr(8'h22, f);
    scl_pin = ln;
    sda_pin = !ln;
    repeat (40) begin
      @(negedge clock);
      hit = hit | bus_abort;
    end
    scl_pin = 1'b1;
    sda_pin = 1'b1;
    // let a late abort from the synchroniser delay pass before the next case
    repeat (4) @(negedge clock);
    check({7'h00, hit}, {7'h00, e});
  endtask : tmo
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  logic [7:0] ra [12] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h19, 8'h20, 8'h21, 8'h22, 8'h31,
                          8'h39, 8'h24, 8'h02};
  logic [7:0] rv [12] = '{8'h00, 8'h07, 8'h55, 8'h55, 8'h55, 8'h55, 8'h0a, 8'h01, 8'h55,
                          8'h55, 8'h00, 8'h5c};
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    host.wr(8'h05, 8'h11);
    host.wr(8'h00, 8'h22);
    rd_chk(8'h05, 8'h55);
    rd_chk(8'h00, 8'h00);
    host.wr(8'h0b, 8'h40);
    rd_chk(8'h05, 8'h40);
    host.wr(8'h11, 8'h12);
    host.wr(8'h09, 8'h08);
    host.wr(8'h11, 8'h34);
    rd_chk(8'h34, 8'h34);
    host.wr(8'h09, 8'h00);
    rd_chk(8'h11, 8'h12);
    host.wr(8'h0f, 8'ha5);
    check({7'h00, conversion_start}, 8'h01);
    @(negedge clock);
    check({7'h00, conversion_start}, 8'h00);
    rd_chk(8'h0f, 8'h00);
    filt(8'h00, 1);
    filt(8'h03, 2);
    filt(8'h06, 3);
    filt(8'h0e, 4);
    rd_chk(8'h01, 8'h60);
    host.wr(8'h22, 8'h10);
    meas(2'h0, 1'b1);
    check({7'h00, alert_chan[0]}, 8'h00);
    check({7'h00, alert_request}, 8'h00);
    host.wr(8'h22, 8'h00);
    meas(2'h0, 1'b1);
    check({7'h00, alert_chan[0]}, 8'h01);
    check({7'h00, alert_request}, 8'h01);
    meas(2'h0, 1'b0);
    check({7'h00, averaging_enable}, 8'h01);
    host.wr(8'h0a, 8'h08);
    repeat (2) @(negedge clock);
    check({7'h00, averaging_enable}, 8'h00);
    tmo(8'h01, 1'b0, 1'b0);
    tmo(8'h80, 1'b0, 1'b1);
    tmo(8'h80, 1'b1, 1'b0);
    tmo(8'h40, 1'b1, 1'b1);
    print_verdict;
  end
  initial begin
    repeat (20000) @(negedge clock);
    err_count++;
    print_verdict;
  end
endmodule : thm_regmap_tb_top
